// File: cisb_pkg.sv
// Shared constants for the increment, skip, branch and OR execution slice
package cisb_pkg;
  // Instruction word layout
  localparam int unsigned INSTR_W = 14;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned FADDR_W = 7;
  localparam int unsigned PC_W = 15;
  localparam int unsigned LATCH_W = 7;
  localparam int unsigned DEST_POS = 7;
  localparam int unsigned BRANCH_LIT_W = 11;
  // Opcode fields: file ops and literal OR decode bits 13..8, branch decodes bits 13..11
  localparam logic [5:0] OP_DEC_SKIP = 6'h0b;
  localparam logic [5:0] OP_INC_FILE = 6'h0a;
  localparam logic [5:0] OP_INC_SKIP = 6'h0f;
  localparam logic [5:0] OP_OR_FILE = 6'h04;
  localparam logic [5:0] OP_OR_LIT = 6'h38;
  localparam logic [2:0] OP_BRANCH = 3'h5;
  // Values after reset
  localparam logic [DATA_W-1:0] W_RST = 8'h00;
  localparam logic [PC_W-1:0] PC_RST = 15'h0000;
  localparam logic ZERO_RST = 1'b0;
  // Execution states, one-hot
  typedef enum logic [1:0] {
    CISB_RUN = 2'b01,
    CISB_NOP = 2'b10
  } cisb_state_e;
endpackage : cisb_pkg

// File: cisb_core.sv
// Execution core for decrement/increment with skip, branch and inclusive OR
`timescale 1ns/10ps

// Functional notes
// - Decrement-and-skip decrements file, destination bit selects target
// - Zero decrement result replaces next instruction with NOP
// - Branch loads literal low, latch bits 6:3 high
// - Branch takes two cycles, flags unchanged
// - Increment file to selected destination, zero updated
// - Increment-and-skip stores, no flags, skips on zero
// - Literal OR into working register, zero updated
// - OR working with file, destination bit selects target
module cisb_core (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic instr_valid_i,
  input wire logic [cisb_pkg::INSTR_W-1:0] instr_i,
  input wire logic [cisb_pkg::DATA_W-1:0] file_rdata_i,
  input wire logic [cisb_pkg::LATCH_W-1:0] pc_latch_i,
  output logic [cisb_pkg::DATA_W-1:0] w_o,
  output logic zero_o,
  output logic file_we_o,
  output logic [cisb_pkg::FADDR_W-1:0] file_waddr_o,
  output logic [cisb_pkg::DATA_W-1:0] file_wdata_o,
  output logic [cisb_pkg::PC_W-1:0] pc_o,
  output logic nop_slot_o
);

  // Operation decode, used by the datapath and the sequencer
  function automatic logic is_op(input logic [cisb_pkg::INSTR_W-1:0] ins,
                                 input logic [5:0] op);
    is_op = (ins[13:8] == op);
  endfunction : is_op

  cisb_pkg::cisb_state_e state_q, state_d;
  logic [cisb_pkg::DATA_W-1:0] w_q, w_d;
  logic zero_q, zero_d;
  logic we_q, we_d;
  logic [cisb_pkg::FADDR_W-1:0] waddr_q, waddr_d;
  logic [cisb_pkg::DATA_W-1:0] wdata_q, wdata_d;
  logic [cisb_pkg::PC_W-1:0] pc_q, pc_d;

  logic take;
  logic op_dec, op_inc, op_incsz, op_orf, op_orl, op_br;
  logic dest_file;
  logic [cisb_pkg::DATA_W-1:0] result;

  // Instructions are only executed in the run state; the slot after a skip or branch is void
  assign take = instr_valid_i && (state_q == cisb_pkg::CISB_RUN);
  assign op_dec = take && is_op(instr_i, cisb_pkg::OP_DEC_SKIP);
  assign op_inc = take && is_op(instr_i, cisb_pkg::OP_INC_FILE);
  assign op_incsz = take && is_op(instr_i, cisb_pkg::OP_INC_SKIP);
  assign op_orf = take && is_op(instr_i, cisb_pkg::OP_OR_FILE);
  assign op_orl = take && is_op(instr_i, cisb_pkg::OP_OR_LIT);
  assign op_br = take && (instr_i[13:11] == cisb_pkg::OP_BRANCH);
  assign dest_file = instr_i[cisb_pkg::DEST_POS];

  // Shared 8-bit result; width kept at 8 so wrap-around at ff/00 is natural
  always_comb
  begin
    result = file_rdata_i;
    if (op_dec)
    begin
      result = file_rdata_i - 8'h01;
    end
    else if (op_inc || op_incsz)
    begin
      result = file_rdata_i + 8'h01;
    end
    else if (op_orf)
    begin
      result = w_q | file_rdata_i;
    end
    else if (op_orl)
    begin
      result = w_q | instr_i[7:0];
    end
  end

  // Datapath next values: working register, zero flag, file write port
  always_comb
  begin
    w_d = w_q;
    zero_d = zero_q;
    we_d = 1'b0;
    waddr_d = waddr_q;
    wdata_d = wdata_q;
    if (op_dec || op_inc || op_incsz || op_orf)
    begin
      if (dest_file)
      begin
        we_d = 1'b1;
        waddr_d = instr_i[cisb_pkg::FADDR_W-1:0];
        wdata_d = result;
      end
      else
      begin
        w_d = result;
      end
    end
    if (op_orl)
    begin
      w_d = result;
    end
    // Decrement-skip and increment-skip leave status alone, as does the branch
    if (op_inc || op_orf || op_orl)
    begin
      zero_d = (result == 8'h00);
    end
  end

  // Sequencer and program counter
  always_comb
  begin
    state_d = state_q;
    pc_d = pc_q;
    unique case (state_q)
      cisb_pkg::CISB_RUN:
      begin
        if (op_br)
        begin
          pc_d = {pc_latch_i[6:3], instr_i[cisb_pkg::BRANCH_LIT_W-1:0]};
          state_d = cisb_pkg::CISB_NOP;
        end
        else if (take)
        begin
          pc_d = pc_q + 15'h0001;
          if ((op_dec || op_incsz) && (result == 8'h00))
          begin
            state_d = cisb_pkg::CISB_NOP;
          end
        end
      end
      cisb_pkg::CISB_NOP:
      begin
        // The discarded instruction still occupies one program slot
        if (instr_valid_i)
        begin
          pc_d = pc_q + 15'h0001;
          state_d = cisb_pkg::CISB_RUN;
        end
      end
      default:
      begin
        state_d = cisb_pkg::CISB_RUN;
      end
    endcase
  end

  // Registers; reset is synchronous
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      state_q <= cisb_pkg::CISB_RUN;
      w_q <= cisb_pkg::W_RST;
      zero_q <= cisb_pkg::ZERO_RST;
      we_q <= 1'b0;
      waddr_q <= 7'h00;
      wdata_q <= 8'h00;
      pc_q <= cisb_pkg::PC_RST;
    end
    else
    begin
      state_q <= state_d;
      w_q <= w_d;
      zero_q <= zero_d;
      we_q <= we_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
      pc_q <= pc_d;
    end
  end

  assign w_o = w_q;
  assign zero_o = zero_q;
  assign file_we_o = we_q;
  assign file_waddr_o = waddr_q;
  assign file_wdata_o = wdata_q;
  assign pc_o = pc_q;
  assign nop_slot_o = state_q[1];

  // Checks
  a_dec_skip_zero: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    op_dec && (file_rdata_i == 8'h01) |=> nop_slot_o)
    else $error("decrement to zero did not void next slot");
  a_dec_no_skip: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    op_dec && (file_rdata_i != 8'h01) && !dest_file
    |=> !nop_slot_o && (w_o == $past(file_rdata_i) - 8'h01))
    else $error("decrement result or skip wrong");
  a_branch_pc: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    op_br |=> pc_o == {$past(pc_latch_i[6:3]), $past(instr_i[10:0])})
    else $error("branch target wrong");
  a_branch_two: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    op_br |=> nop_slot_o && $stable(zero_o) && $stable(w_o))
    else $error("branch not two cycles or flags changed");
  a_inc_file: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    op_inc && dest_file |=> file_we_o && (file_wdata_o == $past(file_rdata_i) + 8'h01)
    && (zero_o == ($past(file_rdata_i) == 8'hff)))
    else $error("increment to file wrong");
  a_incsz_flags: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    op_incsz |=> $stable(zero_o) && (nop_slot_o == ($past(file_rdata_i) == 8'hff)))
    else $error("increment-skip flags or skip wrong");
  a_or_literal: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    op_orl |=> (w_o == ($past(w_o) | $past(instr_i[7:0]))) && !file_we_o)
    else $error("literal OR wrong");
  a_or_file_dest: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    op_orf && dest_file |=> file_we_o && $stable(w_o)
    && (file_wdata_o == ($past(w_o) | $past(file_rdata_i))))
    else $error("file OR wrong");
  a_zero_or: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    op_orf && !dest_file |=> zero_o == (w_o == 8'h00))
    else $error("zero flag does not match result");
  a_nop_skip_once: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    nop_slot_o && instr_valid_i |=> !nop_slot_o && !file_we_o)
    else $error("voided slot executed or lasted too long");
  a_inc_w_zero: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    op_inc && !dest_file |=> !file_we_o && (w_o == $past(file_rdata_i) + 8'h01)
    && (zero_o == ($past(file_rdata_i) == 8'hff)))
    else $error("increment to working register wrong");
  a_incsz_store: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    op_incsz && dest_file |=> file_we_o && $stable(w_o)
    && (file_wdata_o == $past(file_rdata_i) + 8'h01))
    else $error("increment-skip store wrong");
  a_dec_file_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    op_dec && dest_file |=> file_we_o && $stable(zero_o)
    && (file_waddr_o == $past(instr_i[6:0]))
    && (file_wdata_o == $past(file_rdata_i) - 8'h01))
    else $error("decrement store wrong");

endmodule : cisb_core

// File: cisb_file_model.sv
// Behavioural file register bank facing the execution core
`timescale 1ns/10ps
module cisb_file_model (
  input wire logic clk_i,
  input wire logic [cisb_pkg::FADDR_W-1:0] raddr_i,
  output logic [cisb_pkg::DATA_W-1:0] rdata_o,
  input wire logic we_i,
  input wire logic [cisb_pkg::FADDR_W-1:0] waddr_i,
  input wire logic [cisb_pkg::DATA_W-1:0] wdata_i
);
  logic [7:0] mem [128];
  // Address minus one gives the 00 and ff corners at 01 and 00
  initial for (int i = 0; i < 128; i++) mem[i] = 8'(i) - 8'h01;
  // Same-cycle read, as the core expects its operand at once
  assign rdata_o = mem[raddr_i];
  // Write lands on the edge after the strobe, so a read-back waits a cycle
  always @(posedge clk_i) if (we_i) mem[waddr_i] <= wdata_i;
endmodule : cisb_file_model

// File: tb.sv
// Self-checking bench for the execution slice against a file register model
`timescale 1ns/10ps
module tb;
  typedef struct packed {logic [13:0] ins; logic [7:0] w; logic z; logic we;
    logic [7:0] wd;} cisb_row_s;
  logic clk_i, sys_rst_i, instr_valid_i, zero_o, file_we_o, nop_slot_o;
  logic [13:0] instr_i;
  logic [7:0] file_rdata_i, w_o, file_wdata_o;
  logic [6:0] pc_latch_i, file_waddr_o;
  logic [14:0] pc_o, pc_e;
  int n_fail = 0;
  int samples_checked = 0;
  int cycles = 0;
  // Rows run in order: each depends on the W and file state left before it
  // The last two rows: decrement into W with no skip, then an unknown code that only counts
  cisb_row_s rows [11] = '{'{14'h3800, 8'h00, 1'b1, 1'b0, 8'h00},
    '{14'h385a, 8'h5a, 1'b0, 1'b0, 8'h00}, '{14'h0a03, 8'h03, 1'b0, 1'b0, 8'h00},
    '{14'h0a00, 8'h00, 1'b1, 1'b0, 8'h00}, '{14'h0f04, 8'h04, 1'b1, 1'b0, 8'h00},
    '{14'h0405, 8'h04, 1'b0, 1'b0, 8'h00}, '{14'h0487, 8'h04, 1'b0, 1'b1, 8'h06},
    '{14'h0b86, 8'h04, 1'b0, 1'b1, 8'h04}, '{14'h0a87, 8'h04, 1'b0, 1'b1, 8'h07},
    '{14'h0b08, 8'h06, 1'b0, 1'b0, 8'h00}, '{14'h0000, 8'h06, 1'b0, 1'b0, 8'h00}};
  cisb_core u_cisb_core (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .instr_valid_i(instr_valid_i),
    .instr_i(instr_i), .file_rdata_i(file_rdata_i), .pc_latch_i(pc_latch_i), .w_o(w_o),
    .zero_o(zero_o), .file_we_o(file_we_o), .file_waddr_o(file_waddr_o),
    .file_wdata_o(file_wdata_o), .pc_o(pc_o), .nop_slot_o(nop_slot_o));
  cisb_file_model u_cisb_file_model (.clk_i(clk_i), .raddr_i(instr_i[6:0]),
    .rdata_o(file_rdata_i), .we_i(file_we_o), .waddr_i(file_waddr_o), .wdata_i(file_wdata_o));
  // Free-running 20 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  // A hang counts as a mismatch; the whole run needs well under 200 cycles
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      n_fail++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Drive at the falling edge; results are settled by the next falling edge
  task automatic step(input logic [13:0] ins);
    instr_i = ins;
    instr_valid_i = 1'b1;
    pc_e = pc_e + 15'h0001;
    @(negedge clk_i);
  endtask : step
  task automatic do_reset();
    sys_rst_i = 1'b1;
    instr_valid_i = 1'b0;
    repeat (8) @(negedge clk_i);
    sys_rst_i = 1'b0;
    pc_e = 15'h0000;
    chk("rst w", w_o, 16'h0000);
    chk("rst z", zero_o, 16'h0000);
    chk("rst pc", pc_o, 16'h0000);
    chk("rst nop", nop_slot_o, 16'h0000);
    $display("reset test done");
  endtask : do_reset
  initial
  begin
    sys_rst_i = 1'b1;
    instr_valid_i = 1'b0;
    instr_i = 14'h0000;
    pc_latch_i = 7'h5a;
    pc_e = 15'h0000;
    @(negedge clk_i);
    do_reset();
    for (int i = 0; i < 11; i++)
    begin
      step(rows[i].ins);
      chk("w", w_o, rows[i].w);
      chk("z", zero_o, rows[i].z);
      chk("we", file_we_o, rows[i].we);
      if (rows[i].we) chk("waddr", file_waddr_o, rows[i].ins[6:0]);
      if (rows[i].we) chk("wdata", file_wdata_o, rows[i].wd);
      chk("pc", pc_o, pc_e);
      chk("nop", nop_slot_o, 16'h0000);
    end
    $display("row test done");
    // Decrement of 01 into W: the following literal OR must be voided
    step(14'h0b02);
    chk("dec w", w_o, 16'h0000);
    chk("dec nop", nop_slot_o, 16'h0001);
    step(14'h38ff);
    chk("void w", w_o, 16'h0000);
    chk("void nop", nop_slot_o, 16'h0000);
    chk("void pc", pc_o, pc_e);
    $display("decrement skip test done");
    // Increment of ff back to file, then an idle cycle inside the skip
    step(14'h0f80);
    chk("inc we", file_we_o, 16'h0001);
    chk("inc wd", file_wdata_o, 16'h0000);
    chk("inc nop", nop_slot_o, 16'h0001);
    instr_valid_i = 1'b0;
    @(negedge clk_i);
    chk("idle nop", nop_slot_o, 16'h0001);
    step(14'h3801);
    chk("void2 w", w_o, 16'h0000);
    chk("void2 pc", pc_o, pc_e);
    $display("increment skip test done");
    // Branch to the top literal with Z set; latch low bits must not leak in
    step(14'h3800);
    step(14'h2fff);
    pc_e = 15'h5fff;
    chk("br pc", pc_o, pc_e);
    chk("br z", zero_o, 16'h0001);
    chk("br nop", nop_slot_o, 16'h0001);
    step(14'h3801);
    chk("br2 pc", pc_o, pc_e);
    chk("br2 w", w_o, 16'h0000);
    $display("branch test done");
    step(14'h385a);
    chk("pre w", w_o, 16'h005a);
    do_reset();
    end_sim();
  end
endmodule : tb
